//--- core/scp_single_pin_config.sv
// single-pin configuration interface: modes, word ram, storage, readback
// Operation
// - a short high phase, about a fifth of the bit, decodes as zero.
// - a long high phase, about four fifths of the bit, decodes as one.
// - a strobe counted from each rising pin edge samples the registered pin level.
// - every rising pin edge yields at most one captured bit.
// - idle gaps between bits of writes and jumps corrupt nothing.
// - bits repeat at 60 to 80 kHz, nominally 70 kHz.
// - 00 1100 enters programming mode, 11 1011 enters readback mode.
// - entry pulses longer than 16 us abandon the entry sequence.
// - addresses 000, 100 and 010 write words zero, one and two.
// - addresses 110, 001 and 101 write words three, four and five.
// - after the last frame bit the word is latched and applied at once.
// - word writes touch working ram only, never the stored copy.
// - jump 111 1111 0000 enters storage without locking.
// - jump 111 0101 0101 enters storage and sets the lock.
// - jump 111 0000 0000 returns from storage to normal operation.
// - any other 111 pattern exits to normal mode.
// - entering storage while unlocked copies all six words from ram to storage.
// - outside normal mode the enable pin cannot power down.
// - the pin is input only; readback appears on the output pair.
// - prescaler 3 gives feedback 20, prescaler 4 gives feedback 16.
// - once locked, storage is never rewritten.
// - in readback, pin edges shift 59 stored bits onto the output pair.
// - the 61st readback edge returns the pair to normal clock output.
`timescale 1ns/1ns
`default_nettype none
`include "scp_regs.svh"
module scp_single_pin_config #(
  parameter int STROBE_CYC = `SCP_STROBE_CYC,
  parameter int TIMEOUT_CYC = `SCP_TIMEOUT_CYC,
  // arbitrary value
  parameter logic [2:0] REVISION_ID = 3'h1,
  parameter logic [5:0] VCO_CAL = 6'h00
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_config_pin,
  input wire logic chip_enable,
  input wire logic synth_clk,
  output logic [5:0][7:0] config_word_n,
  output logic [5:0] feedback_div,
  output logic power_down,
  output logic prog_mode,
  output logic nvm_busy,
  output logic readback_mode,
  output logic nvm_locked,
  output logic [1:0] clock_output_pair
);
  localparam int CNT_W = $clog2(TIMEOUT_CYC + STROBE_CYC + 1);

  scp_pkg::scp_state_e state;
  scp_pkg::scp_state_e next_state;
  logic rise;
  logic strobe;
  logic bit_value;
  logic long_pulse;
  logic [2:0] entry_cnt;
  logic [4:0] entry_sr;
  logic [5:0] next_entry;
  logic entry_done;
  logic [3:0] frame_cnt;
  logic [10:0] frame_sr;
  logic [10:0] next_frame;
  logic in_frame;
  logic frame_done;
  logic [2:0] frame_addr;
  scp_pkg::scp_word_t frame_payload;
  logic word_write;
  logic store_entry;
  logic [5:0][7:0] nvm;
  logic nvm_written;
  logic [5:0] rb_edges;
  logic [58:0] rb_shift;
  logic rb_head;
  logic rb_bit;

  scp_bit_sampler #(
    .STROBE_CYC(STROBE_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .CNT_W(CNT_W)
  ) u_sampler (
    .clk(clk),
    .reset(reset),
    .pin(serial_config_pin),
    .rise(rise),
    .delayed_config_strobe(strobe),
    .bit_value(bit_value),
    .long_pulse(long_pulse)
  );

  assign next_entry = {entry_sr, bit_value};
  assign entry_done = strobe && state == scp_pkg::st_normal
                      && entry_cnt == `SCP_ENTRY_LAST;
  assign in_frame = state == scp_pkg::st_program
                    || state == scp_pkg::st_store
                    || state == scp_pkg::st_store_lock;
  assign next_frame = {bit_value, frame_sr[10:1]};
  assign frame_done = strobe && in_frame && frame_cnt == `SCP_FRAME_LAST;
  assign frame_addr = next_frame[2:0];
  assign frame_payload = next_frame[10:3];
  assign word_write = frame_done && state == scp_pkg::st_program
                      && frame_addr < `SCP_WORD_COUNT;
  assign store_entry = state == scp_pkg::st_program
                       && (next_state == scp_pkg::st_store
                       || next_state == scp_pkg::st_store_lock);
  assign rb_head = rb_shift[58];

  always_comb
  begin
    next_state = state;
    unique case (state)
      scp_pkg::st_normal:
        if (entry_done && next_entry == `SCP_ENTER_PROG)
          next_state = scp_pkg::st_program;
        else if (entry_done && next_entry == `SCP_ENTER_READBACK)
          next_state = scp_pkg::st_readback;
      scp_pkg::st_program:
        if (frame_done && frame_addr == `SCP_JUMP_ADDR)
        begin
          if (frame_payload == `SCP_JUMP_STORE)
            next_state = scp_pkg::st_store;
          else if (frame_payload == `SCP_JUMP_LOCK)
            next_state = scp_pkg::st_store_lock;
          else
            next_state = scp_pkg::st_normal;
        end
      scp_pkg::st_store, scp_pkg::st_store_lock:
        // the exit jump and every other jump both leave storage
        if (frame_done && frame_addr == `SCP_JUMP_ADDR)
          next_state = scp_pkg::st_normal;
      scp_pkg::st_readback:
        if (rise && rb_edges == `SCP_RB_EXIT_CNT)
          next_state = scp_pkg::st_normal;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= scp_pkg::st_normal;
      prog_mode <= 1'b0;
      nvm_busy <= 1'b0;
      readback_mode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      prog_mode <= next_state == scp_pkg::st_program;
      nvm_busy <= next_state == scp_pkg::st_store
                  || next_state == scp_pkg::st_store_lock;
      readback_mode <= next_state == scp_pkg::st_readback;
    end
  end

  // entry commands are only hunted for in normal mode
  always_ff @(posedge clk)
  begin
    if (reset || state != scp_pkg::st_normal)
    begin
      entry_cnt <= 3'h0;
      entry_sr <= 5'h00;
    end
    else if (strobe)
    begin
      entry_sr <= next_entry[4:0];
      entry_cnt <= entry_done ? 3'h0 : entry_cnt + 3'h1;
    end
    else if (long_pulse)
      entry_cnt <= 3'h0;
  end

  // no time-out here: a frame waits as long as the host likes
  always_ff @(posedge clk)
  begin
    if (reset || !in_frame)
    begin
      frame_cnt <= 4'h0;
      frame_sr <= 11'h000;
    end
    else if (strobe)
    begin
      frame_sr <= next_frame;
      frame_cnt <= frame_done ? 4'h0 : frame_cnt + 4'h1;
    end
  end

  // working ram drives the synthesizer directly, so writes preview at once
  always_ff @(posedge clk)
  begin
    if (reset)
      config_word_n <= `SCP_WORDS_RST;
    else if (word_write)
      config_word_n[frame_addr] <= frame_payload;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      nvm <= `SCP_WORDS_RST;
      nvm_written <= 1'b0;
      nvm_locked <= 1'b0;
    end
    else if (store_entry && !nvm_locked)
    begin
      nvm <= config_word_n;
      nvm_written <= 1'b1;
      if (next_state == scp_pkg::st_store_lock)
        nvm_locked <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      feedback_div <= `SCP_FB_DIV16;
    else
      unique case (config_word_n[0][2:1])
        `SCP_PRESC_5: feedback_div <= `SCP_FB_DIV12;
        `SCP_PRESC_3: feedback_div <= `SCP_FB_DIV20;
        `SCP_PRESC_4: feedback_div <= `SCP_FB_DIV16;
        `SCP_PRESC_2: feedback_div <= `SCP_FB_DIV32;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      power_down <= 1'b0;
    else
      power_down <= state == scp_pkg::st_normal && !chip_enable;
  end

  // edge 1 loads the stored image, edges 2 to 60 shift it out
  always_ff @(posedge clk)
  begin
    if (reset || state != scp_pkg::st_readback)
    begin
      rb_edges <= 6'h00;
      rb_shift <= '0;
      rb_bit <= 1'b0;
    end
    else if (rise)
    begin
      rb_edges <= rb_edges + 6'h01;
      if (rb_edges == 6'h00)
        rb_shift <= {REVISION_ID, VCO_CAL, nvm_written, nvm_locked, nvm};
      else if (rb_edges <= `SCP_RB_BITS)
      begin
        rb_bit <= rb_head;
        rb_shift <= {rb_shift[57:0], 1'b0};
      end
    end
  end

  // the pin has no output path; readback uses the clock pair only
  always_ff @(posedge clk)
  begin
    if (reset)
      clock_output_pair <= 2'h1;
    else if (state == scp_pkg::st_readback)
      clock_output_pair <= {rb_bit, ~rb_bit};
    else
      clock_output_pair <= {synth_clk, ~synth_clk};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_prog_jump;
    state == scp_pkg::st_program && frame_done
      && frame_addr == `SCP_JUMP_ADDR;
  endsequence
  sequence s_store_jump;
    (state == scp_pkg::st_store || state == scp_pkg::st_store_lock)
      && frame_done && frame_addr == `SCP_JUMP_ADDR;
  endsequence

  property p_entry_prog;
    entry_done && next_entry == `SCP_ENTER_PROG
      |=> state == scp_pkg::st_program && prog_mode;
  endproperty
  a_entry_prog: assert property (p_entry_prog)
    else $error("programming entry command not taken");

  property p_timeout;
    state == scp_pkg::st_normal && long_pulse && !strobe
      |=> entry_cnt == 3'h0 && state == scp_pkg::st_normal;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("entry sequence survived a time-out");

  property p_gap;
    in_frame && !strobe |=> frame_cnt == $past(frame_cnt)
      && frame_sr == $past(frame_sr);
  endproperty
  a_gap: assert property (p_gap)
    else $error("frame changed without a bit");

  property p_word_write;
    word_write |=> config_word_n[$past(frame_addr)] == $past(frame_payload)
      && $stable(nvm);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("word write not latched into ram alone");

  property p_store_nolock;
    s_prog_jump ##0 frame_payload == `SCP_JUMP_STORE && !nvm_locked
      |=> state == scp_pkg::st_store && nvm_busy
      ##0 nvm == $past(config_word_n) && !nvm_locked;
  endproperty
  a_store_nolock: assert property (p_store_nolock)
    else $error("storage jump without lock misbehaved");

  property p_store_lock;
    s_prog_jump ##0 frame_payload == `SCP_JUMP_LOCK
      |=> state == scp_pkg::st_store_lock ##0 nvm_locked ##1 nvm_locked;
  endproperty
  a_store_lock: assert property (p_store_lock)
    else $error("locking storage jump did not set the lock");

  property p_store_exit;
    s_store_jump |=> state == scp_pkg::st_normal && !nvm_busy;
  endproperty
  a_store_exit: assert property (p_store_exit)
    else $error("jump from storage did not reach normal mode");

  property p_other_jump;
    s_prog_jump ##0 frame_payload != `SCP_JUMP_STORE
      && frame_payload != `SCP_JUMP_LOCK
      |=> state == scp_pkg::st_normal && !prog_mode;
  endproperty
  a_other_jump: assert property (p_other_jump)
    else $error("undefined jump did not exit to normal mode");

  property p_locked_frozen;
    store_entry && nvm_locked |=> $stable(nvm) ##1 $stable(nvm);
  endproperty
  a_locked_frozen: assert property (p_locked_frozen)
    else $error("locked storage was rewritten");

  property p_no_power_down;
    state != scp_pkg::st_normal |=> !power_down;
  endproperty
  a_no_power_down: assert property (p_no_power_down)
    else $error("power down asserted outside normal mode");

  property p_fb_div;
    (config_word_n[0][2:1] == `SCP_PRESC_3)[*2]
      |-> feedback_div == `SCP_FB_DIV20;
  endproperty
  a_fb_div: assert property (p_fb_div)
    else $error("prescaler 3 did not give feedback 20");

  property p_rb_shift;
    state == scp_pkg::st_readback && rise && rb_edges != 6'h00
      && rb_edges <= `SCP_RB_BITS
      |=> rb_bit == $past(rb_head) ##1 clock_output_pair[1] == $past(rb_bit);
  endproperty
  a_rb_shift: assert property (p_rb_shift)
    else $error("readback bit not shifted onto the output pair");

  property p_rb_exit;
    state == scp_pkg::st_readback && rise && rb_edges == `SCP_RB_EXIT_CNT
      |=> state == scp_pkg::st_normal && !readback_mode
      ##1 clock_output_pair[1] == $past(synth_clk);
  endproperty
  a_rb_exit: assert property (p_rb_exit)
    else $error("61st readback edge did not restore the clock output");
endmodule : scp_single_pin_config
`default_nettype wire

//--- core/scp_regs.svh
// constants of the single-pin configuration interface
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

// timing, derived from the 10 MHz system clock
`define SCP_CLK_KHZ 10000
`define SCP_BIT_NOM_KHZ 70
`define SCP_STROBE_CYC ((`SCP_CLK_KHZ / `SCP_BIT_NOM_KHZ) / 2)
`define SCP_TIMEOUT_US 16
`define SCP_TIMEOUT_CYC ((`SCP_TIMEOUT_US * `SCP_CLK_KHZ) / 1000)

// entry commands, first bit sent in the msb
`define SCP_ENTRY_LAST 3'h5
`define SCP_ENTER_PROG 6'h0c
`define SCP_ENTER_READBACK 6'h3b

// frames: 3 address bits then 8 payload bits, first bit in bit 0
`define SCP_FRAME_LAST 4'ha
`define SCP_WORD_COUNT 3'h6
`define SCP_JUMP_ADDR 3'h7
`define SCP_JUMP_STORE 8'h0f
`define SCP_JUMP_LOCK 8'haa
`define SCP_JUMP_EXIT 8'h00

// working and stored word defaults, word 5 in the top byte
`define SCP_WORDS_RST 48'h0000_0003_5fdc

// prescaler code to feedback divider
`define SCP_PRESC_5 2'h0
`define SCP_PRESC_3 2'h1
`define SCP_PRESC_4 2'h2
`define SCP_PRESC_2 2'h3
`define SCP_FB_DIV12 6'h0c
`define SCP_FB_DIV20 6'h14
`define SCP_FB_DIV16 6'h10
`define SCP_FB_DIV32 6'h20

// readback: 59 bits shifted on edges 2 to 60, edge 61 leaves
`define SCP_RB_BITS 6'h3b
`define SCP_RB_EXIT_CNT 6'h3c

`endif

//--- core/scp_pkg.sv
// shared types of the single-pin configuration interface
`default_nettype none
package scp_pkg;
  typedef enum logic [2:0] {
    st_normal,
    st_program,
    st_store,
    st_store_lock,
    st_readback
  } scp_state_e;
  typedef logic [7:0] scp_word_t;
endpackage : scp_pkg
`default_nettype wire

//--- core/scp_bit_sampler.sv
// bit recovery on the configuration pin: delayed strobe and pulse time-out
`timescale 1ns/1ns
`default_nettype none
module scp_bit_sampler #(
  parameter int STROBE_CYC = 71,
  parameter int TIMEOUT_CYC = 160,
  parameter int CNT_W = 8
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic rise,
  output logic delayed_config_strobe,
  output logic bit_value,
  output logic long_pulse
);
  logic pin_q;
  logic busy;
  logic [CNT_W-1:0] dly_cnt;
  logic [CNT_W-1:0] run_cnt;
  logic edge_now;
  logic change_now;

  assign edge_now = pin & ~pin_q;
  assign change_now = pin ^ pin_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_q <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      pin_q <= pin;
      rise <= edge_now;
    end
  end

  // a new rising edge restarts the delay, so each edge yields at most one strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      dly_cnt <= '0;
      delayed_config_strobe <= 1'b0;
      bit_value <= 1'b0;
    end
    else
    begin
      delayed_config_strobe <= 1'b0;
      if (edge_now)
      begin
        busy <= 1'b1;
        dly_cnt <= CNT_W'(1);
      end
      else if (busy && dly_cnt == CNT_W'(STROBE_CYC))
      begin
        busy <= 1'b0;
        delayed_config_strobe <= 1'b1;
        bit_value <= pin_q;
      end
      else if (busy)
        dly_cnt <= dly_cnt + CNT_W'(1);
    end
  end

  // saturating length of the current high or low pulse
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_cnt <= '0;
      long_pulse <= 1'b0;
    end
    else
    begin
      if (change_now)
        run_cnt <= '0;
      else if (run_cnt != CNT_W'(TIMEOUT_CYC))
        run_cnt <= run_cnt + CNT_W'(1);
      long_pulse <= !change_now && run_cnt == CNT_W'(TIMEOUT_CYC);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_strobe_delay;
    delayed_config_strobe |-> $past(rise, STROBE_CYC);
  endproperty
  a_strobe_delay: assert property (p_strobe_delay)
    else $error("strobe not one half bit after the rising edge");

  property p_bit_level;
    delayed_config_strobe |-> bit_value == $past(pin, 2);
  endproperty
  a_bit_level: assert property (p_bit_level)
    else $error("bit value is not the pin level at the strobe");

  property p_one_bit_per_edge;
    $rose(pin) |=> rise ##1 !rise;
  endproperty
  a_one_bit_per_edge: assert property (p_one_bit_per_edge)
    else $error("rising edge did not start exactly one bit");
endmodule : scp_bit_sampler
`default_nettype wire

//--- dv/scp_host_model.sv
// host model that drives pulse-width-coded bits on the configuration pin
`timescale 1ns/1ns
`default_nettype none
module scp_host_model #(
  parameter int BIT_CYC = 10
)(
  input wire logic clk,
  output logic serial_config_pin
);
  // extra low cycles after each bit, only used inside frames
  int gap_cyc = 0;

  // the host drives the pin low whenever it is idle
  initial serial_config_pin = 1'b0;

  // the bit rate is scaled with the shortened strobe of the bench
  task automatic send_bit(input logic b);
    int hi;
    hi = b ? (BIT_CYC * 4) / 5 : BIT_CYC / 5;
    @(posedge clk);
    #1 serial_config_pin = 1'b1;
    repeat (hi) @(posedge clk);
    #1 serial_config_pin = 1'b0;
    repeat (BIT_CYC - hi - 1 + gap_cyc) @(posedge clk);
  endtask : send_bit

  // the first bit sent is bit n - 1 of v
  task automatic send_seq(input logic [10:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      send_bit(v[i]);
  endtask : send_seq
endmodule : scp_host_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench of the single-pin configuration interface
`timescale 1ns/1ns
`default_nettype none
`include "scp_regs.svh"
module tb;
  localparam int BIT_CYC = 10;
  // the storage model completes at once, so the wait is shortened
  localparam int STORE_WAIT = 3000;
  // arbitrary value
  localparam logic [2:0] REV = 3'h5;
  localparam logic [5:0] VCO = 6'h2a;
  logic clk;
  logic reset;
  logic serial_config_pin;
  logic chip_enable;
  logic synth_clk;
  logic [5:0][7:0] config_word_n;
  logic [5:0] feedback_div;
  logic power_down;
  logic prog_mode;
  logic nvm_busy;
  logic readback_mode;
  logic nvm_locked;
  logic [1:0] clock_output_pair;
  int bad_count = 0;
  int comparisons = 0;
  logic [47:0] ram_exp = `SCP_WORDS_RST;
  logic [47:0] nvm_exp = `SCP_WORDS_RST;
  logic written_exp = 1'b0;
  logic locked_exp = 1'b0;
  logic [2:0] addr_tab [6] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h1, 3'h5};
  logic [7:0] val_tab [6] = '{8'h02, 8'h3c, 8'h5a, 8'h96, 8'he1, 8'h7e};

  scp_single_pin_config #(
    .STROBE_CYC(7),
    .TIMEOUT_CYC(16),
    .REVISION_ID(REV),
    .VCO_CAL(VCO)
  ) i_dut (
    .clk(clk),
    .reset(reset),
    .serial_config_pin(serial_config_pin),
    .chip_enable(chip_enable),
    .synth_clk(synth_clk),
    .config_word_n(config_word_n),
    .feedback_div(feedback_div),
    .power_down(power_down),
    .prog_mode(prog_mode),
    .nvm_busy(nvm_busy),
    .readback_mode(readback_mode),
    .nvm_locked(nvm_locked),
    .clock_output_pair(clock_output_pair)
  );

  scp_host_model #(.BIT_CYC(BIT_CYC)) i_host (
    .clk(clk),
    .serial_config_pin(serial_config_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [63:0] exp,
                       input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic mode_is(input logic [2:0] m);
    check("mode flags", 64'(m),
          64'({prog_mode, nvm_busy, readback_mode}));
  endtask : mode_is

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask : settle

  // payload goes out lsb first, so it is reversed behind the address
  function automatic logic [10:0] frame(input logic [2:0] a,
                                        input logic [7:0] w);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[7 - i] = w[i];
    return {a, r};
  endfunction : frame

  // a long idle low first drops any partial entry pattern
  task automatic enter(input logic [5:0] e);
    repeat (40) @(posedge clk);
    i_host.send_seq({5'h00, e}, 6);
    settle();
  endtask : enter

  task automatic write_word(input int k, input logic [7:0] w);
    i_host.send_seq(frame(addr_tab[k], w), 11);
    settle();
    ram_exp[8 * k +: 8] = w;
  endtask : write_word

  task automatic jump(input logic [10:0] v, input logic [2:0] m);
    i_host.send_seq(v, 11);
    settle();
    mode_is(m);
  endtask : jump

  task automatic t_readback();
    logic [58:0] got;
    logic [58:0] exp;
    logic pair_ok;
    exp = {REV, VCO, written_exp, locked_exp, nvm_exp};
    pair_ok = 1'b1;
    enter(6'h3b);
    mode_is(3'h1);
    chip_enable = 1'b0;
    i_host.send_bit(1'b0);
    for (int k = 0; k < 59; k++)
    begin
      i_host.send_bit(1'b0);
      #1 got[58 - k] = clock_output_pair[1];
      pair_ok &= (clock_output_pair[0] === ~clock_output_pair[1]);
    end
    check("readback stream", 64'(exp), 64'(got));
    check("pair polarity", 64'(1'b1), 64'(pair_ok));
    check("power down", 64'(1'b0), 64'(power_down));
    i_host.send_bit(1'b0);
    settle();
    mode_is(3'h0);
    chip_enable = 1'b1;
    synth_clk = 1'b1;
    repeat (2) @(posedge clk);
    #1 check("output pair", 64'(2'h2), 64'(clock_output_pair));
    synth_clk = 1'b0;
    $display("test readback done");
  endtask : t_readback

  task automatic t_reset();
    check("words", 64'(`SCP_WORDS_RST), 64'(config_word_n));
    check("feedback", 64'(`SCP_FB_DIV16), 64'(feedback_div));
    mode_is(3'h0);
    check("lock", 64'(1'b0), 64'(nvm_locked));
    check("output pair", 64'(2'h1), 64'(clock_output_pair));
    // the flag only follows the enable pin one edge after reset leaves
    check("power down", 64'(1'b0), 64'(power_down));
    @(posedge clk);
    #1 check("power down", 64'(1'b1), 64'(power_down));
    chip_enable = 1'b1;
    repeat (3 * BIT_CYC) @(posedge clk);
    #1 check("power down", 64'(1'b0), 64'(power_down));
    $display("test reset done");
  endtask : t_reset

  task automatic t_timeout();
    i_host.send_seq(11'h001, 3);
    repeat (40) @(posedge clk);
    i_host.send_seq(11'h004, 3);
    settle();
    mode_is(3'h0);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_words();
    enter(6'h0c);
    mode_is(3'h4);
    chip_enable = 1'b0;
    settle();
    check("power down", 64'(1'b0), 64'(power_down));
    chip_enable = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      i_host.gap_cyc = (k == 3) ? 40 : 0;
      write_word(k, val_tab[k]);
      check("words", 64'(ram_exp), 64'(config_word_n));
    end
    check("feedback", 64'(`SCP_FB_DIV20), 64'(feedback_div));
    write_word(0, 8'h00);
    check("feedback", 64'(`SCP_FB_DIV12), 64'(feedback_div));
    write_word(0, 8'h06);
    check("feedback", 64'(`SCP_FB_DIV32), 64'(feedback_div));
    write_word(0, 8'h04);
    check("feedback", 64'(`SCP_FB_DIV16), 64'(feedback_div));
    i_host.send_seq(frame(3'h3, 8'hff), 11);
    settle();
    check("words", 64'(ram_exp), 64'(config_word_n));
    jump(11'h7c3, 3'h0);
    $display("test words done");
    t_readback();
  endtask : t_words

  task automatic t_store();
    enter(6'h0c);
    jump(11'h7f0, 3'h2);
    nvm_exp = ram_exp;
    written_exp = 1'b1;
    repeat (STORE_WAIT) @(posedge clk);
    jump(11'h700, 3'h0);
    t_readback();
    enter(6'h0c);
    jump(11'h755, 3'h2);
    repeat (STORE_WAIT) @(posedge clk);
    jump(11'h700, 3'h0);
    locked_exp = 1'b1;
    check("lock", 64'(1'b1), 64'(nvm_locked));
    enter(6'h0c);
    write_word(5, 8'h00);
    jump(11'h7f0, 3'h2);
    repeat (STORE_WAIT) @(posedge clk);
    jump(11'h700, 3'h0);
    $display("test store done");
    t_readback();
  endtask : t_store

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("unexpected run time: expected finish, seen hang");
    results();
  end

  initial
  begin
    reset = 1'b1;
    chip_enable = 1'b0;
    synth_clk = 1'b0;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    t_reset();
    t_timeout();
    t_words();
    t_store();
    results();
  end
endmodule : tb
`default_nettype wire
